// File: insn_consts.vh
// constants for the 14-bit instruction decoder: field positions,
// operation codes and instruction-cycle timing.
// assumes nothing; definitions only.
`ifndef INSN_CONSTS_VH
`define INSN_CONSTS_VH

`define INSN_W 14
`define OP_W 6
`define LIT_W 11

// oscillator cycles in one instruction cycle
`define OSC_PER_INSN 4
`define PHASE_LAST 2'h3

// field positions
`define F_PREFIX_HI 13
`define F_PREFIX_LO 12
`define F_SUB_HI 11
`define F_SUB_LO 8
`define F_DEST 7
`define F_BIT_HI 9
`define F_BIT_LO 7
`define F_ADDR_HI 6
`define F_PTR_SEL_SHORT 2
`define F_PTR_SEL_LONG 6

// prefixes
`define PFX_BYTE 2'h0
`define PFX_BIT 2'h1
`define PFX_JUMP 2'h2
`define PFX_LIT 2'h3

// indirect location addresses
`define ADDR_IND0 7'h00
`define ADDR_IND1 7'h01

// reset value of the held instruction word (a no-operation)
`define INSN_RESET 14'h0000

// operation codes presented to the datapath
`define OP_NO_OPERATION 6'h00
`define OP_SUB_WITH_BORROW_REG 6'h01
`define OP_NIBBLE_EXCHANGE_REG 6'h02
`define OP_XOR_WORK_REG 6'h03
`define OP_DEC_SKIP_ZERO 6'h04
`define OP_INC_SKIP_ZERO 6'h05
`define OP_BIT_CLEAR 6'h06
`define OP_BIT_SET 6'h07
`define OP_BIT_TEST_SKIP_CLEAR 6'h08
`define OP_BIT_TEST_SKIP_SET 6'h09
`define OP_ADD_LITERAL 6'h0a
`define OP_AND_LITERAL 6'h0b
`define OP_OR_LITERAL 6'h0c
`define OP_XOR_LITERAL 6'h0d
`define OP_SUB_FROM_LITERAL 6'h0e
`define OP_LOAD_LITERAL 6'h0f
`define OP_LOAD_BANK_LITERAL 6'h10
`define OP_LOAD_PC_HIGH_LITERAL 6'h11
`define OP_RELATIVE_JUMP 6'h12
`define OP_RELATIVE_JUMP_BY_WORK 6'h13
`define OP_SUBROUTINE_INVOKE 6'h14
`define OP_ABSOLUTE_JUMP 6'h15
`define OP_SUBROUTINE_INVOKE_BY_WORK 6'h16
`define OP_SUBROUTINE_EXIT 6'h17
`define OP_INTERRUPT_EXIT 6'h18
`define OP_EXIT_WITH_LITERAL 6'h19
`define OP_WATCHDOG_CLEAR 6'h1a
`define OP_STANDBY 6'h1b
`define OP_OPTION_LOAD 6'h1c
`define OP_SOFT_RESET 6'h1d
`define OP_PORT_DIRECTION_LOAD 6'h1e
`define OP_POINTER_ADD_LITERAL 6'h1f
`define OP_INDIRECT_READ_MODIFY 6'h20
`define OP_INDIRECT_READ_INDEXED 6'h21
`define OP_INDIRECT_WRITE_MODIFY 6'h22
`define OP_INDIRECT_WRITE_INDEXED 6'h23
`define OP_BYTE_OTHER 6'h24

`endif

// File: insn_phase_gen.v
// oscillator phase counter: splits each instruction cycle into four
// oscillator cycles and flags the last one.
// assumes core_clk is the oscillator and clk_en gates every edge.
`timescale 1ns/100ps
`include "insn_consts.vh"

module insn_phase_gen (
  input wire core_clk, // oscillator clock
  input wire arst_n, // asynchronous reset, active low
  input wire clk_en, // freezes the counter while low
  output reg [1:0] phase_q, // oscillator cycle within instruction
  output reg last_q // high during the last oscillator cycle
);

  wire [1:0] phase_d;

  assign phase_d = phase_q + 2'h1;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 2'h0;
      last_q <= 1'b0;
    end else if (clk_en) begin
      phase_q <= phase_d;
      last_q <= (phase_d == `PHASE_LAST);
    end
  end

endmodule

// File: insn_decoder.v
// instruction decoder and cycle sequencer for a 14-bit instruction set.
// assumes program memory holds insn_word steady at the PC on every
// core_clk edge ending an instruction cycle, and that the datapath
// drives skip_cond and the pointer top bits on the same clock.
`timescale 1ns/100ps
`include "insn_consts.vh"

module insn_decoder (
  input wire core_clk, // oscillator clock
  input wire arst_n, // asynchronous reset, active low
  input wire clk_en, // freezes all state while low
  input wire [13:0] insn_word, // word from program memory
  input wire skip_cond, // datapath: result zero or bit test true
  input wire ptr0_msb, // top bit of file_select_pointer 0
  input wire ptr1_msb, // top bit of file_select_pointer 1
  output reg [13:0] insn_q, // instruction being executed
  output reg [5:0] op_code_q, // decoded operation
  output reg dest_file_q, // 1: result to file register
  output reg [6:0] reg_addr_q, // file register address
  output reg [2:0] bit_num_q, // bit number for bit operations
  output reg [10:0] literal_q, // literal, sign-extended if signed
  output reg ptr_sel_q, // file_select_pointer number
  output reg [1:0] pointer_modify_mode_q, // pre/post inc/dec mode
  output reg zero_upd_q, // operation updates zero flag
  output reg carry_upd_q, // operation updates carry and digit carry
  output reg time_out_power_down_upd_q, // updates the two power flags
  output reg commit_q, // pulse: instruction effect commits
  output reg word_taken_q, // pulse: a new word was latched
  output wire [1:0] phase_q, // oscillator cycle within instruction
  output wire extra_cycle_q, // extra indirect cycle in progress
  output wire flush_cycle_q // idle second cycle in progress
);

  localparam ST_EXEC = 3'b001;
  localparam ST_EXTRA = 3'b010;
  localparam ST_FLUSH = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg latch_en;
  reg commit_d;
  wire phase_last;
  wire need_extra;
  wire redirect;
  wire [5:0] op_d;

  assign extra_cycle_q = state_q[1];
  assign flush_cycle_q = state_q[2];

  insn_phase_gen u_phase (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .phase_q(phase_q),
    .last_q(phase_last)
  );

  // full-word decode; anything unrecognised falls to no-operation
  function [5:0] decode_op;
    input [13:0] w;
    begin
      decode_op = `OP_NO_OPERATION;
      case (w[`F_PREFIX_HI:`F_PREFIX_LO])
        `PFX_BYTE: begin
          if (w[`F_SUB_HI:`F_SUB_LO] == 4'h0) begin
            if (w[7:0] == 8'h00)
              decode_op = `OP_NO_OPERATION;
            else if (w[7:0] == 8'h01)
              decode_op = `OP_SOFT_RESET;
            else if (w[7:0] == 8'h08)
              decode_op = `OP_SUBROUTINE_EXIT;
            else if (w[7:0] == 8'h09)
              decode_op = `OP_INTERRUPT_EXIT;
            else if (w[7:0] == 8'h0a)
              decode_op = `OP_SUBROUTINE_INVOKE_BY_WORK;
            else if (w[7:0] == 8'h0b)
              decode_op = `OP_RELATIVE_JUMP_BY_WORK;
            else if (w[7:0] == 8'h62)
              decode_op = `OP_OPTION_LOAD;
            else if (w[7:0] == 8'h63)
              decode_op = `OP_STANDBY;
            else if (w[7:0] == 8'h64)
              decode_op = `OP_WATCHDOG_CLEAR;
            else if (w[7:3] == 5'h0c)
              decode_op = `OP_PORT_DIRECTION_LOAD;
            else if (w[7:5] == 3'h1)
              decode_op = `OP_LOAD_BANK_LITERAL;
            else if (w[7:3] == 5'h02)
              decode_op = `OP_INDIRECT_READ_MODIFY;
            else if (w[7:3] == 5'h03)
              decode_op = `OP_INDIRECT_WRITE_MODIFY;
            else if (w[7])
              decode_op = `OP_BYTE_OTHER;
          end else if (w[`F_SUB_HI:`F_SUB_LO] == 4'h6)
            decode_op = `OP_XOR_WORK_REG;
          else if (w[`F_SUB_HI:`F_SUB_LO] == 4'hb)
            decode_op = `OP_DEC_SKIP_ZERO;
          else if (w[`F_SUB_HI:`F_SUB_LO] == 4'hf)
            decode_op = `OP_INC_SKIP_ZERO;
          else if (w[`F_SUB_HI:`F_SUB_LO] == 4'he)
            decode_op = `OP_NIBBLE_EXCHANGE_REG;
          else
            decode_op = `OP_BYTE_OTHER;
        end
        `PFX_BIT: begin
          case (w[11:10])
            2'h0: decode_op = `OP_BIT_CLEAR;
            2'h1: decode_op = `OP_BIT_SET;
            2'h2: decode_op = `OP_BIT_TEST_SKIP_CLEAR;
            default: decode_op = `OP_BIT_TEST_SKIP_SET;
          endcase
        end
        `PFX_JUMP: begin
          if (w[11])
            decode_op = `OP_ABSOLUTE_JUMP;
          else
            decode_op = `OP_SUBROUTINE_INVOKE;
        end
        default: begin
          case (w[`F_SUB_HI:`F_SUB_LO])
            4'hb: decode_op = `OP_SUB_WITH_BORROW_REG;
            4'he: decode_op = `OP_ADD_LITERAL;
            4'h9: decode_op = `OP_AND_LITERAL;
            4'h8: decode_op = `OP_OR_LITERAL;
            4'ha: decode_op = `OP_XOR_LITERAL;
            4'hc: decode_op = `OP_SUB_FROM_LITERAL;
            4'h0: decode_op = `OP_LOAD_LITERAL;
            4'h4: decode_op = `OP_EXIT_WITH_LITERAL;
            4'h2, 4'h3: decode_op = `OP_RELATIVE_JUMP;
            4'h1: begin
              if (w[7])
                decode_op = `OP_LOAD_PC_HIGH_LITERAL;
              else
                decode_op = `OP_POINTER_ADD_LITERAL;
            end
            4'hf: begin
              if (w[7])
                decode_op = `OP_INDIRECT_WRITE_INDEXED;
              else
                decode_op = `OP_INDIRECT_READ_INDEXED;
            end
            4'h5, 4'h6, 4'h7, 4'hd: decode_op = `OP_BYTE_OTHER;
            default: decode_op = `OP_NO_OPERATION;
          endcase
        end
      endcase
    end
  endfunction

  // literal field per operation; offsets are sign-extended so the
  // datapath can add them without knowing the field width
  function [10:0] literal_of;
    input [5:0] op;
    input [13:0] w;
    begin
      case (op)
        `OP_SUBROUTINE_INVOKE, `OP_ABSOLUTE_JUMP:
          literal_of = w[10:0];
        `OP_RELATIVE_JUMP:
          literal_of = {{2{w[8]}}, w[8:0]};
        `OP_LOAD_PC_HIGH_LITERAL:
          literal_of = {4'h0, w[6:0]};
        `OP_LOAD_BANK_LITERAL:
          literal_of = {6'h00, w[4:0]};
        `OP_POINTER_ADD_LITERAL, `OP_INDIRECT_READ_INDEXED,
        `OP_INDIRECT_WRITE_INDEXED:
          literal_of = {{5{w[5]}}, w[5:0]};
        `OP_PORT_DIRECTION_LOAD:
          literal_of = {8'h00, w[2:0]};
        default:
          literal_of = {3'h0, w[7:0]};
      endcase
    end
  endfunction

  // file register operations on location 0 or 1, and indirect reads and writes, whose pointer has its top bit set
  function indirect_hit;
    input [5:0] op;
    input [6:0] addr;
    input sel;
    input m0;
    input m1;
    reg direct_op;
    reg ptr_op;
    begin
      direct_op = (op >= `OP_SUB_WITH_BORROW_REG &&
                   op <= `OP_BIT_TEST_SKIP_SET) ||
                  op == `OP_BYTE_OTHER;
      ptr_op = op >= `OP_INDIRECT_READ_MODIFY &&
               op <= `OP_INDIRECT_WRITE_INDEXED;
      indirect_hit = (direct_op && addr == `ADDR_IND0 && m0) ||
                     (direct_op && addr == `ADDR_IND1 && m1) ||
                     (ptr_op && (sel ? m1 : m0));
    end
  endfunction

  // skip operations redirect only when the datapath reports the
  // tested condition true
  function is_skip_op;
    input [5:0] op;
    begin
      is_skip_op = op == `OP_DEC_SKIP_ZERO ||
                   op == `OP_INC_SKIP_ZERO ||
                   op == `OP_BIT_TEST_SKIP_CLEAR ||
                   op == `OP_BIT_TEST_SKIP_SET;
    end
  endfunction

  // every operation that loads the program counter
  function is_control_op;
    input [5:0] op;
    begin
      is_control_op = op >= `OP_RELATIVE_JUMP &&
                      op <= `OP_EXIT_WITH_LITERAL;
    end
  endfunction

  // modified forms carry the pointer number low, the others high
  function ptr_sel_of;
    input [5:0] op;
    input [13:0] w;
    begin
      if (op == `OP_INDIRECT_READ_MODIFY ||
          op == `OP_INDIRECT_WRITE_MODIFY)
        ptr_sel_of = w[`F_PTR_SEL_SHORT];
      else
        ptr_sel_of = w[`F_PTR_SEL_LONG];
    end
  endfunction

  assign op_d = decode_op(insn_word);
  assign need_extra = indirect_hit(op_code_q, reg_addr_q, ptr_sel_q,
                                   ptr0_msb, ptr1_msb);
  // pc-changing operations always redirect; skips only when true
  assign redirect = is_control_op(op_code_q) ||
                    (is_skip_op(op_code_q) && skip_cond);

  always @* begin
    state_d = state_q;
    latch_en = 1'b0;
    commit_d = 1'b0;
    case (state_q)
      ST_EXEC: begin
        if (need_extra) begin
          state_d = ST_EXTRA;
        end else begin
          commit_d = 1'b1;
          if (redirect) begin
            state_d = ST_FLUSH;
          end else begin
            latch_en = 1'b1;
          end
        end
      end
      ST_EXTRA: begin
        commit_d = 1'b1;
        if (redirect) begin
          state_d = ST_FLUSH;
        end else begin
          state_d = ST_EXEC;
          latch_en = 1'b1;
        end
      end
      ST_FLUSH: begin
        state_d = ST_EXEC;
        latch_en = 1'b1;
      end
      default: begin
        state_d = ST_EXEC;
        latch_en = 1'b1;
      end
    endcase
  end

  // the word is taken only at the last oscillator cycle, so the
  // fetch for the next instruction overlaps the current one
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_EXEC;
      insn_q <= `INSN_RESET;
      op_code_q <= `OP_NO_OPERATION;
      dest_file_q <= 1'b0;
      reg_addr_q <= 7'h00;
      bit_num_q <= 3'h0;
      literal_q <= 11'h000;
      ptr_sel_q <= 1'b0;
      pointer_modify_mode_q <= 2'h0;
      zero_upd_q <= 1'b0;
      carry_upd_q <= 1'b0;
      time_out_power_down_upd_q <= 1'b0;
      commit_q <= 1'b0;
      word_taken_q <= 1'b0;
    end else if (clk_en) begin
      // pulses hold through a freeze as well; the datapath shares
      // clk_en, so it still acts on each pulse once
      commit_q <= phase_last & commit_d;
      word_taken_q <= phase_last & latch_en;
      if (phase_last) begin
        state_q <= state_d;
      end
      if (phase_last && latch_en) begin
        insn_q <= insn_word;
        op_code_q <= op_d;
        dest_file_q <= insn_word[`F_DEST];
        reg_addr_q <= insn_word[`F_ADDR_HI:0];
        bit_num_q <= insn_word[`F_BIT_HI:`F_BIT_LO];
        literal_q <= literal_of(op_d, insn_word);
        ptr_sel_q <= ptr_sel_of(op_d, insn_word);
        pointer_modify_mode_q <= insn_word[1:0];
        zero_upd_q <= op_d == `OP_SUB_WITH_BORROW_REG ||
                      op_d == `OP_XOR_WORK_REG ||
                      (op_d >= `OP_ADD_LITERAL &&
                       op_d <= `OP_SUB_FROM_LITERAL) ||
                      op_d == `OP_INDIRECT_READ_MODIFY ||
                      op_d == `OP_INDIRECT_READ_INDEXED;
        carry_upd_q <= op_d == `OP_SUB_WITH_BORROW_REG ||
                       op_d == `OP_ADD_LITERAL ||
                       op_d == `OP_SUB_FROM_LITERAL;
        time_out_power_down_upd_q <= op_d == `OP_STANDBY ||
                                     op_d == `OP_WATCHDOG_CLEAR;
      end
    end
  end

endmodule

// File: insn_decoder_props.sv
// timing and decoding checks on the instruction decoder's ports.
// assumes it is bound into insn_decoder and sees its ports only.
`timescale 1ns/100ps
`include "insn_consts.vh"

module insn_decoder_chk (
  input wire core_clk, // oscillator clock
  input wire arst_n, // reset, active low
  input wire clk_en, // clock enable
  input wire [13:0] insn_q, // held word
  input wire [5:0] op_code_q, // decoded operation
  input wire [2:0] bit_num_q, // bit number
  input wire [10:0] literal_q, // literal
  input wire zero_upd_q, // zero flag update
  input wire time_out_power_down_upd_q, // power flag update
  input wire commit_q, // commit pulse
  input wire word_taken_q, // take pulse
  input wire [1:0] phase_q, // oscillator cycle
  input wire extra_cycle_q, // extra indirect cycle
  input wire flush_cycle_q // idle second cycle
);
  // frozen cycles stretch every count, so they are not judged
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n || !clk_en);

  a_take_pulse: assert property ($rose(word_taken_q) |->
    $past(phase_q) == 2'h3 ##1 !word_taken_q) else $error("bad take");
  a_fields_stand: assert property (!word_taken_q |->
    $stable(op_code_q) && $stable(insn_q)) else $error("fields moved");
  a_flush_len: assert property ($rose(flush_cycle_q) |->
    commit_q && !word_taken_q ##0 flush_cycle_q[*4]
    ##1 (word_taken_q && !flush_cycle_q)) else $error("bad flush");
  a_extra_len: assert property ($rose(extra_cycle_q) |->
    (extra_cycle_q && !commit_q)[*4] ##1 commit_q)
    else $error("bad extra cycle");
  a_jump_flush: assert property (word_taken_q && op_code_q inside
    {[`OP_RELATIVE_JUMP:`OP_EXIT_WITH_LITERAL]} |-> ##4 flush_cycle_q)
    else $error("control op without idle cycle");
  a_single_take: assert property (word_taken_q && op_code_q inside
    {`OP_NO_OPERATION, [`OP_ADD_LITERAL:`OP_LOAD_PC_HIGH_LITERAL],
    [`OP_WATCHDOG_CLEAR:`OP_POINTER_ADD_LITERAL]} |-> ##4 word_taken_q)
    else $error("single op not one cycle");
  a_power_flags: assert property (word_taken_q |->
    time_out_power_down_upd_q ==
    (op_code_q inside {`OP_WATCHDOG_CLEAR, `OP_STANDBY}))
    else $error("power flag update wrong");
  a_bit_decode: assert property (word_taken_q && insn_q[13:12] == 2'h1
    |-> op_code_q == `OP_BIT_CLEAR + insn_q[11:10] &&
    bit_num_q == insn_q[9:7]) else $error("bit op decode wrong");
  a_literal_ops: assert property (word_taken_q &&
    insn_q[13:8] == 6'h3e |-> op_code_q == `OP_ADD_LITERAL &&
    literal_q == {3'h0, insn_q[7:0]}) else $error("literal decode wrong");
  a_write_status: assert property (op_code_q inside
    {`OP_INDIRECT_WRITE_MODIFY, `OP_INDIRECT_WRITE_INDEXED}
    |-> !zero_upd_q) else $error("write touches status");
endmodule

bind insn_decoder insn_decoder_chk chk_u (.core_clk, .arst_n, .clk_en,
  .insn_q, .op_code_q, .bit_num_q, .literal_q, .zero_upd_q,
  .time_out_power_down_upd_q, .commit_q, .word_taken_q, .phase_q,
  .extra_cycle_q, .flush_cycle_q);

// File: prog_mem_model.sv
// program memory model: presents the word at the fetch address.
// assumes the decoder pulses word_taken_q once per latched word.
`timescale 1ns/100ps

module prog_mem_model (
  input wire core_clk, // oscillator clock
  input wire arst_n, // reset, active low
  input wire word_taken_q, // fetch pulse from the decoder
  output wire [13:0] insn_word // word at the fetch address
);
  reg [13:0] mem [0:255];
  reg [7:0] pc_q;
  integer i;
  // unwritten slots hold no-operation words
  initial begin
    for (i = 0; i < 256; i = i + 1) mem[i] = 14'h0000;
  end
  // pc follows the take pulse only, so a freeze must not fall while
  // the pulse is high
  assign insn_word = mem[pc_q];
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) pc_q <= 8'h00;
    else if (word_taken_q) pc_q <= pc_q + 8'h01;
  end
endmodule

// File: test_midrange_insn_decoder.sv
// self-checking bench: decoder fed by the program memory model.
// assumes the memory model and the checker are compiled before it.
`timescale 1ns/100ps
`include "insn_consts.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  mismatches++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end

module test_midrange_insn_decoder;
  reg core_clk = 1'b0;
  reg arst_n = 1'b0;
  reg clk_en = 1'b1;
  reg skip_cond = 1'b0;
  reg ptr0_msb = 1'b0;
  reg ptr1_msb = 1'b0;
  wire [13:0] insn_word, insn_q;
  wire [5:0] op_code_q;
  wire [6:0] reg_addr_q;
  wire [2:0] bit_num_q;
  wire [10:0] literal_q;
  wire [1:0] pointer_modify_mode_q, phase_q;
  wire dest_file_q, ptr_sel_q, zero_upd_q, carry_upd_q, commit_q;
  wire time_out_power_down_upd_q, word_taken_q;
  wire extra_cycle_q, flush_cycle_q;
  int mismatches = 0;
  int num_checks = 0;
  reg [10:0] c_lit;
  reg [6:0] c_addr;
  reg [2:0] c_bit;
  reg [1:0] c_mode;
  reg c_dest, c_sel, c_z, c_c, c_t;

  insn_decoder dut_u (.core_clk, .arst_n, .clk_en, .insn_word,
    .skip_cond, .ptr0_msb, .ptr1_msb, .insn_q, .op_code_q, .dest_file_q,
    .reg_addr_q, .bit_num_q, .literal_q, .ptr_sel_q,
    .pointer_modify_mode_q, .zero_upd_q, .carry_upd_q,
    .time_out_power_down_upd_q, .commit_q, .word_taken_q, .phase_q,
    .extra_cycle_q, .flush_cycle_q);
  prog_mem_model pm_u (.core_clk, .arst_n, .word_taken_q, .insn_word);

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // sm: bit0 skip condition, bit1/bit2 pointer 0/1 top bits
  task automatic run(input [13:0] w, input [2:0] sm, input [5:0] op,
    input int cyc);
    int k;
    k = 0;
    // one slot ahead of the fetch address, so never fetched early
    pm_u.mem[pm_u.pc_q + 8'h01] = w;
    do begin
      @(negedge core_clk);
      k++;
    end while (!(word_taken_q === 1'b1 && insn_q === w) && k < 40);
    if (k >= 40) begin
      mismatches++;
      final_report;
    end
    {c_lit, c_addr, c_bit, c_mode} =
      {literal_q, reg_addr_q, bit_num_q, pointer_modify_mode_q};
    {c_dest, c_sel, c_z, c_c, c_t} = {dest_file_q, ptr_sel_q,
      zero_upd_q, carry_upd_q, time_out_power_down_upd_q};
    `CHK(op_code_q, op)
    @(posedge core_clk);
    {ptr1_msb, ptr0_msb, skip_cond} <= sm;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (word_taken_q !== 1'b1 && k < 20);
    `CHK(k, `OSC_PER_INSN * cyc)
    if (k >= 20) final_report;
    @(posedge core_clk);
    {ptr1_msb, ptr0_msb, skip_cond} <= 3'h0;
  endtask

  task t_byte;
    run(14'h3b85, 3'h0, `OP_SUB_WITH_BORROW_REG, 1);
    `CHK({c_dest, c_addr, c_c}, {1'b1, 7'h05, 1'b1})
    run(14'h0605, 3'h0, `OP_XOR_WORK_REG, 1);
    `CHK({c_dest, c_z, c_c}, 3'b010)
    run(14'h0e07, 3'h0, `OP_NIBBLE_EXCHANGE_REG, 1);
    run(14'h0b85, 3'h1, `OP_DEC_SKIP_ZERO, 2);
    run(14'h0f05, 3'h0, `OP_INC_SKIP_ZERO, 1);
    run(14'h0f05, 3'h1, `OP_INC_SKIP_ZERO, 2);
  endtask

  task t_bit;
    for (int b = 0; b < 4; b++) begin
      run({2'h1, b[1:0], 3'h5, 7'h22}, 3'h1, `OP_BIT_CLEAR + b[5:0],
        b / 2 + 1);
      `CHK({c_bit, c_addr}, {3'h5, 7'h22})
    end
    run(14'h1aa2, 3'h0, `OP_BIT_TEST_SKIP_CLEAR, 1);
  endtask

  task t_lit;
    logic [3:0] sub [6] = '{4'he, 4'h9, 4'h8, 4'ha, 4'hc, 4'h0};
    for (int i = 0; i < 6; i++) begin
      run({2'h3, sub[i], 8'ha5}, 3'h0, `OP_ADD_LITERAL + i[5:0], 1);
      `CHK(c_lit, 11'h0a5)
    end
    run(14'h31ff, 3'h0, `OP_LOAD_PC_HIGH_LITERAL, 1);
    `CHK(c_lit, 11'h07f)
    run(14'h003f, 3'h0, `OP_LOAD_BANK_LITERAL, 1);
    `CHK(c_lit, 11'h01f)
  endtask

  task t_ctl;
    logic [13:0] w [8] = '{14'h3380, 14'h000b, 14'h2123, 14'h2923,
      14'h000a, 14'h0008, 14'h0009, 14'h3455};
    for (int i = 0; i < 8; i++) begin
      run(w[i], 3'h0, `OP_RELATIVE_JUMP + i[5:0], 2);
      if (i == 0) `CHK(c_lit, 11'h780)
      if (i == 3) `CHK(c_lit, 11'h123)
    end
    `CHK(c_lit, 11'h055)
  endtask

  task t_inh;
    logic [13:0] w [8] = '{14'h0063, 14'h0064, 14'h0062, 14'h0065,
      14'h0001, 14'h0000, 14'h0002, 14'h0068};
    logic [5:0] op [8] = '{`OP_STANDBY, `OP_WATCHDOG_CLEAR,
      `OP_OPTION_LOAD, `OP_PORT_DIRECTION_LOAD, `OP_SOFT_RESET,
      `OP_NO_OPERATION, `OP_NO_OPERATION, `OP_NO_OPERATION};
    for (int i = 0; i < 8; i++) begin
      run(w[i], 3'h1, op[i], 1);
      `CHK(c_t, i < 2)
      if (i == 3) `CHK(c_lit, 11'h005)
    end
  endtask

  task t_ind;
    run(14'h317f, 3'h0, `OP_POINTER_ADD_LITERAL, 1);
    `CHK({c_sel, c_lit}, {1'b1, 11'h7ff})
    run(14'h0016, 3'h4, `OP_INDIRECT_READ_MODIFY, 2);
    `CHK({c_sel, c_mode, c_z}, 4'b1101)
    run(14'h3f20, 3'h4, `OP_INDIRECT_READ_INDEXED, 1);
    `CHK({c_sel, c_lit, c_z}, {1'b0, 11'h7e0, 1'b1})
    run(14'h001c, 3'h2, `OP_INDIRECT_WRITE_MODIFY, 1);
    `CHK({c_sel, c_z, c_c}, 3'b100)
    run(14'h3fc1, 3'h4, `OP_INDIRECT_WRITE_INDEXED, 2);
    `CHK({c_lit, c_z}, {11'h001, 1'b0})
    run(14'h0681, 3'h4, `OP_XOR_WORK_REG, 2);
    run(14'h0b80, 3'h3, `OP_DEC_SKIP_ZERO, 3);
  endtask

  // clk_en dropped mid-instruction, away from the take pulse
  task t_freeze;
    int k;
    run(14'h3e5a, 3'h0, `OP_ADD_LITERAL, 1);
    clk_en <= 1'b0;
    repeat (3) @(negedge core_clk);
    `CHK(phase_q, 2'h1)
    @(posedge core_clk);
    clk_en <= 1'b1;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (word_taken_q !== 1'b1 && k < 20);
    // one still-frozen edge, then the three left of the instruction
    `CHK(k, `OSC_PER_INSN)
    if (k >= 20) final_report;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    t_byte;
    t_bit;
    t_lit;
    t_ctl;
    t_inh;
    t_ind;
    t_freeze;
    final_report;
  end
endmodule
